// file: rtl/aob_cfg.svh
`ifndef AOB_CFG_SVH
`define AOB_CFG_SVH

// Datapath geometry.
`define AOB_DATA_W 16
`define AOB_INDEX_W 9
`define AOB_OPREG_DEPTH 512
`define AOB_EXIT_DEPTH 16
`define AOB_EXIT_W 4
`define AOB_STACK_WORDS 64
`define AOB_STEP_W 3

// Reset and preset values.
`define AOB_ZERO_DATA 16'h0000
`define AOB_ZERO_INDEX 9'h000
`define AOB_ZERO_EXIT 4'h0
`define AOB_ZERO_STEP 3'h0
`define AOB_PLUS_ONE 16'h0001
`define AOB_MINUS_ONE 16'hffff
`define AOB_EXIT_STEP 4'h1
`define AOB_EXIT_LIMIT 4'he

// Cycle numbers counted from issue.
`define AOB_CP1 3'h1
`define AOB_CP2 3'h2
`define AOB_CP3 3'h3
`define AOB_CP4 3'h4

`endif

// file: rtl/aob_pkg.sv
package aob_pkg;

  typedef enum logic [3:0] {
    OP_IDX_DEC,
    OP_LOAD,
    OP_AND,
    OP_ADD,
    OP_SUB,
    OP_STORE,
    OP_ADD_STORE,
    OP_INC,
    OP_DEC,
    OP_JMP_FWD,
    OP_JMP_BWD,
    OP_CALL_FWD
  } aob_op_e;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RUN,
    ST_FETCH,
    ST_LOAD,
    ST_DECODE
  } aob_state_e;

endpackage

// file: rtl/aob_adder.sv
`timescale 1ns/1ps
`include "aob_cfg.svh"

module aob_adder #(
  parameter int W = `AOB_DATA_W
) (
  // Operands.
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  input wire logic sub,
  // Result.
  output logic [W-1:0] sum,
  output logic carry_out
);

  logic [W:0] first;
  logic [W:0] second;

  // Subtraction is two passes, complement-add then plus one, so carry can leave either.
  always_comb begin
    first = {1'b0, a} + {1'b0, (sub ? ~b : b)};
    second = {1'b0, first[W-1:0]} + {{W{1'b0}}, sub};
    sum = second[W-1:0];
    carry_out = first[W] | (sub & second[W]);
  end

endmodule

// file: rtl/aob_opreg_file.sv
`timescale 1ns/1ps
`include "aob_cfg.svh"

module aob_opreg_file #(
  parameter int DEPTH = `AOB_OPREG_DEPTH,
  parameter int W = `AOB_DATA_W,
  parameter int IW = `AOB_INDEX_W
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Read port.
  input wire logic [IW-1:0] rd_index,
  output logic [W-1:0] rd_data,
  // Write port.
  input wire logic wr_en,
  input wire logic [IW-1:0] wr_index,
  input wire logic [W-1:0] wr_data
);

  logic [W-1:0] mem_reg [DEPTH];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_entry
      always_ff @(posedge clock) begin
        if (reset) begin
          mem_reg[g] <= `AOB_ZERO_DATA;
        end else if (wr_en && (wr_index == IW'(g))) begin
          mem_reg[g] <= wr_data;
        end
      end
    end
  endgenerate

  assign rd_data = mem_reg[rd_index];

endmodule

// file: rtl/aob_unit.sv
`timescale 1ns/1ps
`include "aob_cfg.svh"

// Behaviour
// (RULE1) Index decrement: preset minus one, add, write back.
// (RULE2) Operand load: pointer, then accumulator, clear carry.
// (RULE3) Operand AND at accumulator input, clears carry.
// (RULE4) Operand add: addend cycle 1, accumulator cycle 3.
// (RULE5) Subtract: complement, add, plus one, same timing.
// (RULE6) Pointer-writing ops wait while destination pointer busy.
// (RULE7) Store writes cycle 1, waits for late accumulator.
// (RULE8) Add-and-store drops, reloads pointer, writes cycle 4.
// (RULE9) Add-and-store add step waits for accumulator.
// (RULE10) Operand increment: clear carry, plus one, add.
// (RULE11) Operand decrement: clear carry, all ones, add.
// (RULE12) Forward jump adds zero-extended offset, state kept.
// (RULE13) Backward jump subtracts offset, state kept.
// (RULE14) Jumps: base and offset, add, load address.
// (RULE15) In-stack target held cycle 2, issues cycle 4.
// (RULE16) Out-of-stack target fetched, held, decoded, issued.
// (RULE17) Wait for memory acceptance, load data next cycle.
// (RULE18) Call advances exit index, pushes return address.
// (RULE19) Sixteen-bit accumulator, nine-bit unsigned index.
// (RULE20) Index decrement returns low nine bits only.
// (RULE21) Boundary flag when advanced exit index is 14.
// (RULE22) Store leaves accumulator and carry untouched.
module aob_unit #(
  parameter int W = `AOB_DATA_W,
  parameter int IW = `AOB_INDEX_W,
  parameter int OPREG_DEPTH = `AOB_OPREG_DEPTH,
  parameter int STACK_WORDS = `AOB_STACK_WORDS
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Instruction issue.
  input wire logic issue_valid,
  input wire aob_pkg::aob_op_e issue_op,
  input wire logic [IW-1:0] issue_index,
  input wire logic [W-1:0] issue_addr,
  output logic issue_ready,
  output logic busy,
  // Accumulator data from other units not yet ready.
  input wire logic acc_late,
  // Operand register preload.
  input wire logic preload_en,
  input wire logic [IW-1:0] preload_index,
  input wire logic [W-1:0] preload_data,
  // Index write-back.
  output logic index_wr_en,
  output logic [IW-1:0] index_wr_data,
  // Instruction stack.
  input wire logic [W-1:0] stack_base,
  output logic [W-1:0] stack_rd_addr,
  input wire logic [W-1:0] stack_rd_data,
  // Instruction memory fetch.
  input wire logic fetch_busy,
  output logic fetch_req,
  output logic [W-1:0] fetch_addr,
  input wire logic mem_accept,
  input wire logic [W-1:0] mem_data,
  // Architectural state.
  output logic [W-1:0] accumulator,
  output logic carry,
  output logic [W-1:0] program_addr,
  output logic [W-1:0] holding_data,
  output logic holding_valid,
  output logic [`AOB_EXIT_W-1:0] exit_index,
  output logic [W-1:0] exit_top,
  output logic exit_boundary
);

  aob_pkg::aob_state_e st_reg;
  aob_pkg::aob_op_e op_reg;
  logic [`AOB_STEP_W-1:0] step_reg;
  logic [W-1:0] acc_reg;
  logic carry_reg;
  logic [W-1:0] addend_reg;
  logic [W-1:0] base_reg;
  logic [W-1:0] sum_reg;
  logic sum_carry_reg;
  logic [IW-1:0] rp_reg;
  logic rp_valid_reg;
  logic [IW-1:0] dp_reg;
  logic dp_valid_reg;
  logic [W-1:0] p_reg;
  logic [W-1:0] hold_reg;
  logic hold_valid_reg;
  logic [`AOB_EXIT_W-1:0] exit_idx_reg;
  logic [W-1:0] exit_mem_reg [`AOB_EXIT_DEPTH];
  logic boundary_reg;
  logic idx_wr_reg;
  logic [IW-1:0] idx_data_reg;
  logic [W-1:0] op_rd_data;
  logic [W-1:0] add_a;
  logic [W-1:0] add_sum;
  logic add_carry;
  logic add_sub;
  logic op_wr_en;
  logic [IW-1:0] op_wr_index;
  logic [W-1:0] op_wr_data;
  logic is_branch;
  logic is_call;
  logic uses_dp;
  logic in_stack;
  logic stall;
  logic last_step;
  logic fire;
  logic [W-1:0] stack_off;
  logic [W-1:0] index_ext;

  assign index_ext = {{(W-IW){1'b0}}, issue_index};
  assign is_branch = (op_reg == aob_pkg::OP_JMP_FWD) || (op_reg == aob_pkg::OP_JMP_BWD)
                     || (op_reg == aob_pkg::OP_CALL_FWD);
  assign is_call = (op_reg == aob_pkg::OP_CALL_FWD);
  assign uses_dp = (issue_op == aob_pkg::OP_STORE) || (issue_op == aob_pkg::OP_ADD_STORE)
                   || (issue_op == aob_pkg::OP_INC) || (issue_op == aob_pkg::OP_DEC);
  // Issue is serialised; the pointer check also covers pointers left by earlier work.
  assign issue_ready = (st_reg == aob_pkg::ST_IDLE) && !(uses_dp && dp_valid_reg); // [RULE6]
  assign fire = issue_valid && issue_ready;
  assign busy = (st_reg != aob_pkg::ST_IDLE);

  // Only the store write and the add-and-store add step depend on accumulator data.
  assign stall = (st_reg == aob_pkg::ST_RUN) && acc_late
                 && (((op_reg == aob_pkg::OP_STORE) && (step_reg == `AOB_CP1))
                 || ((op_reg == aob_pkg::OP_ADD_STORE) && (step_reg == `AOB_CP2))); // [RULE7] [RULE9]

  always_comb begin
    unique case (op_reg)
      aob_pkg::OP_LOAD, aob_pkg::OP_AND, aob_pkg::OP_STORE: last_step = (step_reg == `AOB_CP1);
      aob_pkg::OP_IDX_DEC, aob_pkg::OP_ADD, aob_pkg::OP_SUB: last_step = (step_reg == `AOB_CP3);
      aob_pkg::OP_ADD_STORE, aob_pkg::OP_INC, aob_pkg::OP_DEC: last_step = (step_reg == `AOB_CP4);
      aob_pkg::OP_JMP_FWD, aob_pkg::OP_JMP_BWD, aob_pkg::OP_CALL_FWD:
        last_step = (step_reg == `AOB_CP3);
      // Unused operation codes end at once so a corrupt code cannot hang issue.
      default: last_step = 1'b1;
    endcase
  end

  assign stack_off = sum_reg - stack_base;
  assign in_stack = (stack_off < W'(STACK_WORDS));
  assign stack_rd_addr = sum_reg;

  // Branches use their own base so the accumulator is never disturbed.
  assign add_a = is_branch ? base_reg : acc_reg; // [RULE12] [RULE13]
  assign add_sub = (op_reg == aob_pkg::OP_SUB) || (op_reg == aob_pkg::OP_JMP_BWD); // [RULE5] [RULE13]

  aob_adder #(.W(W)) u_adder (
    .a(add_a),
    .b(addend_reg),
    .sub(add_sub),
    .sum(add_sum),
    .carry_out(add_carry)
  );

  assign op_wr_en = preload_en || ((st_reg == aob_pkg::ST_RUN) && !stall
                    && (((op_reg == aob_pkg::OP_STORE) && (step_reg == `AOB_CP1))
                    || (((op_reg == aob_pkg::OP_ADD_STORE) || (op_reg == aob_pkg::OP_INC)
                    || (op_reg == aob_pkg::OP_DEC)) && (step_reg == `AOB_CP4)))); // [RULE7] [RULE8]
  assign op_wr_index = preload_en ? preload_index : dp_reg;
  assign op_wr_data = preload_en ? preload_data : acc_reg;

  aob_opreg_file #(.DEPTH(OPREG_DEPTH), .W(W), .IW(IW)) u_opregs (
    .clock(clock),
    .reset(reset),
    .rd_index(rp_reg),
    .rd_data(op_rd_data),
    .wr_en(op_wr_en),
    .wr_index(op_wr_index),
    .wr_data(op_wr_data)
  );

  // Sequencer.
  always_ff @(posedge clock) begin
    if (reset) begin
      st_reg <= aob_pkg::ST_IDLE;
      step_reg <= `AOB_ZERO_STEP;
      op_reg <= aob_pkg::OP_LOAD;
    end else begin
      unique case (st_reg)
        aob_pkg::ST_IDLE: begin
          if (fire) begin
            st_reg <= aob_pkg::ST_RUN;
            op_reg <= issue_op;
            step_reg <= `AOB_CP1;
          end
        end
        aob_pkg::ST_RUN: begin
          if (is_branch && (step_reg == `AOB_CP2) && !in_stack) begin
            st_reg <= aob_pkg::ST_FETCH; // [RULE16]
          end else if (last_step && !stall) begin
            st_reg <= aob_pkg::ST_IDLE; // [RULE14] [RULE15]
          end else if (!stall) begin
            step_reg <= step_reg + `AOB_CP1;
          end
        end
        aob_pkg::ST_FETCH: begin
          if (fetch_req && mem_accept) begin
            st_reg <= aob_pkg::ST_LOAD; // [RULE17]
          end
        end
        aob_pkg::ST_LOAD: st_reg <= aob_pkg::ST_DECODE;
        aob_pkg::ST_DECODE: st_reg <= aob_pkg::ST_IDLE; // [RULE16]
      endcase
    end
  end

  // Accumulator and carry.
  always_ff @(posedge clock) begin
    if (reset) begin
      acc_reg <= `AOB_ZERO_DATA;
      carry_reg <= 1'b0;
    end else if (fire && (issue_op == aob_pkg::OP_IDX_DEC)) begin
      acc_reg <= `AOB_MINUS_ONE; // [RULE1]
      carry_reg <= 1'b0; // [RULE20]
    end else if (fire && ((issue_op == aob_pkg::OP_INC) || (issue_op == aob_pkg::OP_DEC))) begin
      carry_reg <= 1'b0; // [RULE10] [RULE11]
    end else if ((st_reg == aob_pkg::ST_RUN) && !stall) begin
      unique case (op_reg)
        aob_pkg::OP_LOAD: begin
          acc_reg <= op_rd_data; // [RULE2]
          carry_reg <= 1'b0;
        end
        aob_pkg::OP_AND: begin
          acc_reg <= acc_reg & op_rd_data; // [RULE3]
          carry_reg <= 1'b0;
        end
        aob_pkg::OP_IDX_DEC: begin
          if (step_reg == `AOB_CP2) begin
            acc_reg <= sum_reg; // [RULE1] [RULE19]
            carry_reg <= carry_reg ^ sum_carry_reg; // [RULE20]
          end
        end
        aob_pkg::OP_ADD, aob_pkg::OP_SUB, aob_pkg::OP_ADD_STORE: begin
          if (step_reg == `AOB_CP3) begin
            acc_reg <= sum_reg; // [RULE4] [RULE5] [RULE8]
            carry_reg <= carry_reg ^ sum_carry_reg;
          end
        end
        aob_pkg::OP_INC, aob_pkg::OP_DEC: begin
          if (step_reg == `AOB_CP1) begin
            acc_reg <= (op_reg == aob_pkg::OP_INC) ? `AOB_PLUS_ONE : `AOB_MINUS_ONE; // [RULE10] [RULE11]
          end else if (step_reg == `AOB_CP3) begin
            acc_reg <= sum_reg; // [RULE10] [RULE11]
            carry_reg <= carry_reg ^ sum_carry_reg;
          end
        end
        // Store and branches leave accumulator and carry alone.
        default: begin
          acc_reg <= acc_reg; // [RULE22] [RULE12] [RULE13]
        end
      endcase
    end
  end

  // Addend, branch base and adder result.
  always_ff @(posedge clock) begin
    if (reset) begin
      addend_reg <= `AOB_ZERO_DATA;
      base_reg <= `AOB_ZERO_DATA;
      sum_reg <= `AOB_ZERO_DATA;
      sum_carry_reg <= 1'b0;
    end else begin
      if (fire) begin
        addend_reg <= index_ext; // [RULE1] [RULE14] [RULE19]
        base_reg <= issue_addr; // [RULE14]
      end else if ((st_reg == aob_pkg::ST_RUN) && (step_reg == `AOB_CP1) && !is_branch
                   && (op_reg != aob_pkg::OP_IDX_DEC)) begin
        addend_reg <= op_rd_data; // [RULE4] [RULE10] [RULE11]
      end
      if ((st_reg == aob_pkg::ST_RUN) && !stall
          && ((((op_reg == aob_pkg::OP_IDX_DEC) || is_branch) && (step_reg == `AOB_CP1))
          || ((op_reg != aob_pkg::OP_IDX_DEC) && !is_branch && (step_reg == `AOB_CP2)))) begin
        sum_reg <= add_sum; // [RULE4] [RULE9] [RULE14]
        sum_carry_reg <= add_carry; // [RULE5]
      end
    end
  end

  // Read and destination pointers.
  always_ff @(posedge clock) begin
    if (reset) begin
      rp_reg <= `AOB_ZERO_INDEX;
      rp_valid_reg <= 1'b0;
      dp_reg <= `AOB_ZERO_INDEX;
      dp_valid_reg <= 1'b0;
    end else if (fire) begin
      rp_reg <= issue_index; // [RULE2] [RULE7]
      rp_valid_reg <= 1'b1;
      if (uses_dp) begin
        dp_reg <= issue_index; // [RULE7]
        dp_valid_reg <= 1'b1;
      end
    end else if ((st_reg == aob_pkg::ST_RUN) && !stall) begin
      if ((op_reg == aob_pkg::OP_ADD_STORE) || (op_reg == aob_pkg::OP_INC)
          || (op_reg == aob_pkg::OP_DEC)) begin
        if (step_reg == `AOB_CP1) begin
          rp_valid_reg <= 1'b0; // [RULE8]
        end else if (step_reg == `AOB_CP3) begin
          rp_reg <= dp_reg; // [RULE8]
          rp_valid_reg <= 1'b1;
        end
      end
      if (op_wr_en && !preload_en) begin
        dp_valid_reg <= 1'b0; // [RULE6]
      end
    end
  end

  // Index write-back.
  always_ff @(posedge clock) begin
    if (reset) begin
      idx_wr_reg <= 1'b0;
      idx_data_reg <= `AOB_ZERO_INDEX;
    end else begin
      idx_wr_reg <= (st_reg == aob_pkg::ST_RUN) && (op_reg == aob_pkg::OP_IDX_DEC)
                    && (step_reg == `AOB_CP3);
      if ((st_reg == aob_pkg::ST_RUN) && (op_reg == aob_pkg::OP_IDX_DEC)
          && (step_reg == `AOB_CP3)) begin
        idx_data_reg <= acc_reg[IW-1:0]; // [RULE1] [RULE20]
      end
    end
  end

  // Program address and issue holding register.
  always_ff @(posedge clock) begin
    if (reset) begin
      p_reg <= `AOB_ZERO_DATA;
      hold_reg <= `AOB_ZERO_DATA;
      hold_valid_reg <= 1'b0;
    end else if ((st_reg == aob_pkg::ST_RUN) && is_branch && (step_reg == `AOB_CP2)) begin
      p_reg <= sum_reg; // [RULE14]
      hold_valid_reg <= in_stack;
      if (in_stack) begin
        hold_reg <= stack_rd_data; // [RULE15]
      end
    end else if (st_reg == aob_pkg::ST_LOAD) begin
      hold_reg <= mem_data; // [RULE16] [RULE17]
      hold_valid_reg <= 1'b1;
    end
  end

  // Exit stack for calls.
  always_ff @(posedge clock) begin
    if (reset) begin
      exit_idx_reg <= `AOB_ZERO_EXIT;
      boundary_reg <= 1'b0;
    end else if ((st_reg == aob_pkg::ST_RUN) && is_call && (step_reg == `AOB_CP1)) begin
      exit_idx_reg <= exit_idx_reg + `AOB_EXIT_STEP; // [RULE18]
      if ((exit_idx_reg + `AOB_EXIT_STEP) == `AOB_EXIT_LIMIT) begin
        boundary_reg <= 1'b1; // [RULE21]
      end
    end
  end

  genvar e;
  generate
    for (e = 0; e < `AOB_EXIT_DEPTH; e++) begin : g_exit
      always_ff @(posedge clock) begin
        if (reset) begin
          exit_mem_reg[e] <= `AOB_ZERO_DATA;
        end else if ((st_reg == aob_pkg::ST_RUN) && is_call && (step_reg == `AOB_CP2)
                     && (exit_idx_reg == `AOB_EXIT_W'(e))) begin
          exit_mem_reg[e] <= base_reg + `AOB_PLUS_ONE; // [RULE18]
        end
      end
    end
  endgenerate

  // A pending internal fetch simply holds the request off; memory conflicts show as late accept.
  assign fetch_req = (st_reg == aob_pkg::ST_FETCH) && !fetch_busy; // [RULE16] [RULE17]
  assign fetch_addr = p_reg;
  assign accumulator = acc_reg;
  assign carry = carry_reg;
  assign program_addr = p_reg;
  assign holding_data = hold_reg;
  assign holding_valid = hold_valid_reg;
  assign exit_index = exit_idx_reg;
  assign exit_top = exit_mem_reg[exit_idx_reg];
  assign exit_boundary = boundary_reg;
  assign index_wr_en = idx_wr_reg;
  assign index_wr_data = idx_data_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  chk_idx_writeback: assert property (index_wr_en |-> index_wr_data == accumulator[IW-1:0]) // [RULE1]
    else $error("index write-back differs from accumulator low bits");
  chk_load_value: assert property ((st_reg == aob_pkg::ST_RUN) && (op_reg == aob_pkg::OP_LOAD)
    |=> (accumulator == $past(op_rd_data)) && !carry) // [RULE2]
    else $error("operand load result wrong");
  chk_and_value: assert property ((st_reg == aob_pkg::ST_RUN) && (op_reg == aob_pkg::OP_AND)
    |=> (accumulator == ($past(accumulator) & $past(op_rd_data))) && !carry) // [RULE3]
    else $error("operand and result wrong");
  chk_add_timing: assert property (fire && (issue_op == aob_pkg::OP_ADD)
    |=> busy [*3] ##1 issue_ready) // [RULE4]
    else $error("operand add timing wrong");
  chk_dp_interlock: assert property (dp_valid_reg && uses_dp |-> !issue_ready) // [RULE6]
    else $error("issue allowed with destination pointer busy");
  chk_store_wait: assert property (stall && (op_reg == aob_pkg::OP_STORE)
    |=> $stable(rp_reg) && $stable(dp_reg) && (step_reg == `AOB_CP1)) // [RULE7]
    else $error("store did not hold pointers while waiting");
  chk_branch_keep: assert property (fire && (issue_op == aob_pkg::OP_JMP_FWD)
    |=> ($stable(accumulator) && $stable(carry)) [*3]) // [RULE12]
    else $error("jump altered accumulator or carry");
  chk_exit_boundary: assert property ((st_reg == aob_pkg::ST_RUN) && is_call
    && (step_reg == `AOB_CP1) && (exit_idx_reg == 4'hd) |=> exit_boundary) // [RULE21]
    else $error("exit boundary flag not set");
  chk_fetch_load: assert property (fetch_req && mem_accept
    |=> ##1 (holding_data == $past(mem_data)) && holding_valid ##1 issue_ready) // [RULE17]
    else $error("fetched instruction not loaded in time");

endmodule

// file: verif/aob_imem_model.sv
`timescale 1ns/1ps

// Instruction memory: accepts a branch fetch after a set conflict delay.
module aob_imem_model (
  // Clock and delay setting.
  input wire logic clock,
  input wire logic [3:0] delay,
  // Fetch request and answer.
  input wire logic fetch_req,
  input wire logic [15:0] fetch_addr,
  output logic mem_accept,
  output logic [15:0] mem_data,
  // Instruction stack lookup.
  input wire logic [15:0] stack_rd_addr,
  output logic [15:0] stack_rd_data
);
  logic [3:0] wait_reg = 4'h0;

  initial begin
    mem_accept = 1'b0;
    mem_data = 16'h0000;
  end

  // The stack answers within the cycle, as the lookup is combinational.
  assign stack_rd_data = stack_rd_addr ^ 16'h5a5a;

  always @(posedge clock) begin
    // Data is valid for one cycle only, so a late sample sees a changed word.
    mem_data <= ~mem_data;
    if (fetch_req && mem_accept) begin
      mem_accept <= 1'b0;
      mem_data <= fetch_addr ^ 16'hc3c3;
      wait_reg <= 4'h0;
    end else if (fetch_req) begin
      if (wait_reg == delay)
        mem_accept <= 1'b1;
      else
        wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule

// file: verif/aob_unit_tb.sv
`timescale 1ns/1ps

module aob_unit_tb;
  logic clock, reset, issue_valid, acc_late, preload_en, fetch_busy;
  aob_pkg::aob_op_e issue_op;
  logic [8:0] issue_index, preload_index, index_wr_data;
  logic [15:0] issue_addr, preload_data, stack_rd_addr, stack_rd_data;
  logic [15:0] fetch_addr, mem_data, accumulator, program_addr, holding_data, exit_top;
  logic issue_ready, busy, index_wr_en, fetch_req, mem_accept, carry, holding_valid;
  logic exit_boundary;
  logic [3:0] exit_index;
  logic [3:0] mem_delay;
  int error_cnt = 0;
  int tests_run = 0;

  aob_unit aob_unit_inst (
    .clock(clock), .reset(reset), .issue_valid(issue_valid), .issue_op(issue_op),
    .issue_index(issue_index), .issue_addr(issue_addr), .issue_ready(issue_ready),
    .busy(busy), .acc_late(acc_late), .preload_en(preload_en),
    .preload_index(preload_index), .preload_data(preload_data),
    .index_wr_en(index_wr_en), .index_wr_data(index_wr_data),
    .stack_base(16'h1000), .stack_rd_addr(stack_rd_addr), .stack_rd_data(stack_rd_data),
    .fetch_busy(fetch_busy), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .mem_accept(mem_accept), .mem_data(mem_data), .accumulator(accumulator),
    .carry(carry), .program_addr(program_addr), .holding_data(holding_data),
    .holding_valid(holding_valid), .exit_index(exit_index), .exit_top(exit_top),
    .exit_boundary(exit_boundary)
  );

  aob_imem_model aob_imem_model_inst (
    .clock(clock), .delay(mem_delay), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .mem_accept(mem_accept), .mem_data(mem_data), .stack_rd_addr(stack_rd_addr),
    .stack_rd_data(stack_rd_data)
  );

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic cmp16(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cmp1(input string name, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic preload(input logic [8:0] idx, input logic [15:0] data);
    @(negedge clock);
    preload_en = 1'b1;
    preload_index = idx;
    preload_data = data;
    @(negedge clock);
    preload_en = 1'b0;
  endtask

  // Issues one instruction and counts cycles until issue is allowed again.
  // Cycles s to e-1 hold both stall inputs high; only the op that cares reacts.
  task automatic run(input aob_pkg::aob_op_e op, input logic [8:0] idx,
                     input logic [15:0] addr, input int s, input int e, output int n);
    @(negedge clock);
    while (issue_ready !== 1'b1)
      @(negedge clock);
    issue_valid = 1'b1;
    issue_op = op;
    issue_index = idx;
    issue_addr = addr;
    @(negedge clock);
    issue_valid = 1'b0;
    n = 1;
    while (n < 100) begin
      acc_late = n >= s && n < e;
      fetch_busy = acc_late;
      if (issue_ready === 1'b1)
        break;
      @(negedge clock);
      n++;
    end
  endtask

  task automatic ld(input logic [8:0] idx, input logic [15:0] exp);
    int n;
    run(aob_pkg::OP_LOAD, idx, 16'h0000, 0, 0, n);
    cmp16("load cycles", 16'd2, 16'(n));
    cmp16("load acc", exp, accumulator);
    cmp1("load carry", 1'b0, carry);
  endtask

  task automatic alu(input aob_pkg::aob_op_e op, input logic [8:0] idx, input int cyc,
                     input logic [15:0] ea, input logic ec);
    int n;
    run(op, idx, 16'h0000, 0, 0, n);
    cmp16("alu cycles", 16'(cyc), 16'(n));
    cmp16("alu acc", ea, accumulator);
    cmp1("alu carry", ec, carry);
  endtask

  task automatic t_store();
    int n;
    run(aob_pkg::OP_STORE, 9'h009, 16'h0000, 1, 3, n);
    cmp16("store cycles", 16'd4, 16'(n));
    cmp16("store acc", 16'h022e, accumulator);
    cmp1("store carry", 1'b0, carry);
    ld(9'h009, 16'h022e);
  endtask

  task automatic t_addst();
    int n;
    run(aob_pkg::OP_ADD_STORE, 9'h00a, 16'h0000, 2, 3, n);
    cmp16("addst cycles", 16'd6, 16'(n));
    cmp16("addst acc", 16'h023e, accumulator);
    ld(9'h00a, 16'h023e);
  endtask

  task automatic t_idxdec();
    int n;
    run(aob_pkg::OP_IDX_DEC, 9'h100, 16'h0000, 0, 0, n);
    cmp16("idxdec cycles", 16'd4, 16'(n));
    cmp1("idx wr en", 1'b1, index_wr_en);
    cmp16("idx data", 16'h00ff, {7'h00, index_wr_data});
    cmp16("idxdec acc", 16'h00ff, accumulator);
    cmp1("idxdec carry", 1'b1, carry);
    @(negedge clock);
    cmp1("idx wr pulse", 1'b0, index_wr_en);
  endtask

  task automatic t_jumps();
    int n;
    run(aob_pkg::OP_JMP_FWD, 9'h020, 16'h1000, 0, 0, n);
    cmp16("jf cycles", 16'd4, 16'(n));
    cmp16("jf target", 16'h1020, program_addr);
    cmp16("jf holding", 16'h1020 ^ 16'h5a5a, holding_data);
    cmp16("jf acc", 16'h00ff, accumulator);
    run(aob_pkg::OP_JMP_BWD, 9'h1ff, 16'h1000, 3, 5, n);
    cmp16("jb cycles", 16'd11, 16'(n));
    cmp16("jb target", 16'h0e01, program_addr);
    cmp16("jb fetch", 16'h0e01, fetch_addr);
    cmp16("jb holding", 16'h0e01 ^ 16'hc3c3, holding_data);
    cmp1("jb valid", 1'b1, holding_valid);
    cmp16("jb acc", 16'h00ff, accumulator);
    cmp1("jb carry", 1'b1, carry);
    cmp1("jb busy", 1'b0, busy);
  endtask

  task automatic t_call();
    int n;
    for (int i = 1; i <= 14; i++) begin
      run(aob_pkg::OP_CALL_FWD, 9'h001, 16'h1000 + 16'(i), 0, 0, n);
      cmp16("call index", 16'(i), {12'h000, exit_index});
      cmp16("call return", 16'h1001 + 16'(i), exit_top);
      cmp16("call target", 16'h1001 + 16'(i), program_addr);
      cmp1("call boundary", i == 14, exit_boundary);
    end
    cmp16("call acc", 16'h00ff, accumulator);
    cmp1("call carry", 1'b1, carry);
  endtask

  initial begin
    #(50 * 3000);
    error_cnt++;
    print_verdict();
  end

  initial begin
    reset = 1'b1;
    issue_valid = 1'b0;
    issue_op = aob_pkg::OP_LOAD;
    issue_index = 9'h000;
    issue_addr = 16'h0000;
    acc_late = 1'b0;
    fetch_busy = 1'b0;
    preload_en = 1'b0;
    preload_index = 9'h000;
    preload_data = 16'h0000;
    mem_delay = 4'h2;
    repeat (6) @(negedge clock);
    reset = 1'b0;
    preload(9'h005, 16'h1234);
    preload(9'h006, 16'h0ff0);
    preload(9'h007, 16'hffff);
    preload(9'h008, 16'h0001);
    preload(9'h00a, 16'h0010);
    preload(9'h00b, 16'hffff);
    preload(9'h00c, 16'h0000);
    ld(9'h005, 16'h1234);
    alu(aob_pkg::OP_AND, 9'h006, 2, 16'h0230, 1'b0);
    alu(aob_pkg::OP_ADD, 9'h007, 4, 16'h022f, 1'b1);
    alu(aob_pkg::OP_SUB, 9'h008, 4, 16'h022e, 1'b0);
    t_store();
    t_addst();
    alu(aob_pkg::OP_INC, 9'h00b, 5, 16'h0000, 1'b1);
    ld(9'h00b, 16'h0000);
    alu(aob_pkg::OP_DEC, 9'h00c, 5, 16'hffff, 1'b0);
    ld(9'h00c, 16'hffff);
    t_idxdec();
    t_jumps();
    t_call();
    print_verdict();
  end
endmodule
